/* hdl/burst_sram_device.sv */
// Pipelined burst SRAM device core with no turnaround latency, plus its write buffer.
// Assumes all pins but output_drive_n_i and the asynchronous rstn_i synchronous to clk_sys_i; the data pins are split into in, out and enable.
//
// Contract
// [RULE1] Write strobe low starts write, sampled when qualified
// [RULE2] Advance high increments internal burst counter
// [RULE3] Advance low loads a fresh address
// [RULE4] Controller loads new address after deselect
// [RULE5] Qualifier high: edge and inputs ignored
// [RULE6] Qualifier high stretches cycle, keeps selection
// [RULE7] Selected only with low, high, low selects
// [RULE8] Output-drive input low permits driving data pins
// [RULE9] Tristate in write data phase and deselect
// [RULE10] Read data from previous edge, registered
// [RULE11] Write data captured on rising clock edge
// [RULE12] Parity lines follow their lane's write select
// [RULE13] Four lane write selects qualified by strobe
// [RULE14] Burst order strap fixed, high means interleaved
// [RULE15] Selected load latches address, read or write
// [RULE16] Burst wraps within four words, selected order
// [RULE17] Write data two qualified edges after command
`timescale 1ns/100ps
`default_nettype none

// Small ready/valid FIFO holding writes until the array port is free
module wbuf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [0:DEPTH-1]; // Entry storage
  logic [PW-1:0] wr_ptr_r; // Next slot to fill
  logic [PW-1:0] rd_ptr_r; // Oldest entry
  logic [PW:0] count_r; // Entries held
  logic push, pop; // Handshakes that complete this edge

  assign in_ready_o = (count_r != (PW+1)'(DEPTH));
  assign out_valid_o = (count_r != '0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = store[rd_ptr_r];

  // Storage has no reset; only the occupied slots are ever read
  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      store[wr_ptr_r] <= in_data_i;
    end
  end

  // Pointers wrap naturally since the depth is a power of two
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      count_r <= count_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule // wbuf_fifo

module burst_sram_device (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic [burst_sram_pkg::ADDR_W-1:0] addr_i,
  input wire logic write_strobe_n_i,
  input wire logic advance_or_load_i,
  input wire logic clock_qualifier_n_i,
  input wire logic select_low_a_n_i,
  input wire logic select_high_i,
  input wire logic select_low_b_n_i,
  input wire logic [burst_sram_pkg::LANES-1:0] byte_lane_write_n_i,
  input wire logic output_drive_n_i,
  input wire logic burst_order_i,
  input wire logic [burst_sram_pkg::DATA_W-1:0] data_i,
  input wire logic [burst_sram_pkg::LANES-1:0] parity_lines_i,
  output logic [burst_sram_pkg::DATA_W-1:0] data_o,
  output logic [burst_sram_pkg::LANES-1:0] parity_lines_o,
  output logic data_oe_o,
  output logic write_buf_ready_o
);
  import burst_sram_pkg::*;

  logic [LANE_W-1:0] mem [0:WORDS-1][0:LANES-1]; // Array, lane-sliced
  logic qual, sel_ok, load, adv; // Recognised edge, selecting pattern, load edge, advance edge
  logic [BURST_W-1:0] cnt_nxt, low_nxt; // Counter and low address bits after an advance
  logic [ADDR_W-1:0] acc_addr; // Address of this edge's access
  logic acc_vld, acc_wr, rd_now; // Access starts or continues, is a write, uses the read port
  logic order_r, strap_done_r; // Captured burst order strap and its capture flag
  logic [ADDR_W-1:0] base_r; // Burst start address
  logic [BURST_W-1:0] cnt_r; // Burst counter
  logic act_r, wr_mode_r; // Selected so the burst may continue; the burst writes
  logic st1_vld_r, st1_wr_r, st2_vld_r, st2_wr_r; // Command pipeline flags, two qualified stages
  logic [ADDR_W-1:0] st1_addr_r, st2_addr_r; // Command pipeline addresses
  logic [LANES-1:0] st1_bw_n_r, st2_bw_n_r; // Lane write selects, active low
  logic [LANES*LANE_W-1:0] mem_q_r, dout_r, pin_lanes; // Array read register, output register, pins as lanes
  logic drive_r, push; // Internal permission to drive; write data phase edge
  logic [WBUF_W-1:0] push_data, wq_out_data; // Buffer entry going in and coming out
  logic wq_in_ready, wq_out_valid; // Buffer handshake
  logic [ADDR_W-1:0] wq_addr; // Address of the oldest buffered write
  logic [LANES-1:0] wq_mask; // Its lane mask, active high

  assign qual = !clock_qualifier_n_i; // RULE5
  assign sel_ok = !select_low_a_n_i && select_high_i && !select_low_b_n_i; // RULE7
  assign load = qual && !advance_or_load_i; // RULE3
  assign adv = qual && advance_or_load_i; // RULE2
  assign cnt_nxt = cnt_r + 1'b1;

  // Wrap inside the four-word group in the strapped order
  assign low_nxt = (order_r == ORDER_LINEAR) ? base_r[BURST_W-1:0] + cnt_nxt // RULE16
    : base_r[BURST_W-1:0] ^ cnt_nxt;

  // Pick the access of this edge: a fresh address or the next burst word
  always_comb begin
    if (load) begin
      acc_addr = addr_i; // RULE15
      acc_vld = sel_ok; // RULE7
      acc_wr = !write_strobe_n_i; // RULE1
    end else begin
      acc_addr = {base_r[ADDR_W-1:BURST_W], low_nxt};
      acc_vld = adv && act_r; // Advance after deselect stays deselected
      acc_wr = wr_mode_r;
    end
  end

  assign rd_now = acc_vld && !acc_wr && qual;

  // Strap is caught once after reset release so later wiggles do no harm
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      order_r <= ORDER_RST;
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      order_r <= burst_order_i; // RULE14
      strap_done_r <= 1'b1;
    end
  end

  // Burst state: base, counter, selection; frozen on unqualified edges
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      base_r <= ADDR_RST;
      cnt_r <= CNT_RST;
      act_r <= 1'b0;
      wr_mode_r <= 1'b0;
    end else if (load) begin
      base_r <= addr_i; // RULE3
      cnt_r <= CNT_RST;
      act_r <= sel_ok; // RULE7
      wr_mode_r <= !write_strobe_n_i; // RULE1
    end else if (adv && act_r) begin
      cnt_r <= cnt_nxt; // RULE2
    end
  end

  // Command pipeline, two qualified stages; selection survives suspension
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st1_vld_r <= 1'b0;
      st1_wr_r <= 1'b0;
      st1_addr_r <= ADDR_RST;
      st1_bw_n_r <= LANE_N_RST;
      st2_vld_r <= 1'b0;
      st2_wr_r <= 1'b0;
      st2_addr_r <= ADDR_RST;
      st2_bw_n_r <= LANE_N_RST;
    end else if (qual) begin // RULE6
      st1_vld_r <= acc_vld;
      st1_wr_r <= acc_wr;
      st1_addr_r <= acc_addr;
      st1_bw_n_r <= byte_lane_write_n_i; // RULE13
      st2_vld_r <= st1_vld_r;
      st2_wr_r <= st1_wr_r;
      st2_addr_r <= st1_addr_r;
      st2_bw_n_r <= st1_bw_n_r;
    end
  end

  // Array read at the command edge, then the output register one edge later
  always_ff @(posedge clk_sys_i) begin
    if (rd_now) begin
      for (int k = 0; k < LANES; k++) begin
        mem_q_r[k*LANE_W +: LANE_W] <= mem[acc_addr][k]; // RULE10
      end
    end
  end

  // Output register and drive permission; a write or deselect never enables
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dout_r <= '0;
      drive_r <= 1'b0;
    end else if (qual) begin
      dout_r <= mem_q_r; // RULE10
      drive_r <= st1_vld_r && !st1_wr_r; // RULE9
    end
  end

  // Output-drive pin is asynchronous, so it gates the enable without a flop
  assign data_oe_o = drive_r && !output_drive_n_i; // RULE8
  always_comb begin
    for (int k = 0; k < LANES; k++) begin
      data_o[k*8 +: 8] = dout_r[k*LANE_W +: 8];
      parity_lines_o[k] = dout_r[k*LANE_W+8]; // RULE12
      pin_lanes[k*LANE_W +: LANE_W] = {parity_lines_i[k], data_i[k*8 +: 8]}; // RULE12
    end
  end

  // Write data is taken two qualified edges after its command
  assign push = qual && st2_vld_r && st2_wr_r; // RULE17
  assign push_data = {st2_addr_r, ~st2_bw_n_r, pin_lanes}; // RULE11

  // Writes wait here while reads own the single array port
  wbuf_fifo #(
    .WIDTH(WBUF_W),
    .DEPTH(WBUF_DEPTH)
  ) u_wbuf (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .in_valid_i(push),
    .in_ready_o(wq_in_ready),
    .in_data_i(push_data),
    .out_valid_o(wq_out_valid),
    .out_ready_i(!rd_now),
    .out_data_o(wq_out_data)
  );

  assign wq_addr = wq_out_data[WBUF_W-1 -: ADDR_W];
  assign wq_mask = wq_out_data[LANES*LANE_W +: LANES];

  // Drain one buffered write per free port cycle, lane by lane
  always_ff @(posedge clk_sys_i) begin
    if (wq_out_valid && !rd_now) begin
      for (int k = 0; k < LANES; k++) begin
        if (wq_mask[k]) begin
          mem[wq_addr][k] <= wq_out_data[k*LANE_W +: LANE_W]; // RULE13
        end
      end
    end
  end

  // Buffer room shown to the controller, one cycle late
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      write_buf_ready_o <= 1'b1;
    end else begin
      write_buf_ready_o <= wq_in_ready;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  a_write_tristate: assert property (st2_vld_r && st2_wr_r |-> !data_oe_o) // RULE9
    else $error("data pins driven in write data phase");
  a_drive_gate: assert property (output_drive_n_i |-> !data_oe_o) // RULE8
    else $error("data pins driven while output drive high");
  a_suspend_hold: assert property (clock_qualifier_n_i |=> $stable(st1_vld_r) && $stable(drive_r)
    && $stable(cnt_r) && $stable(dout_r)) // RULE6
    else $error("state changed on suspended edge");
  a_load_addr: assert property (load && sel_ok |=> st1_vld_r && st1_addr_r == $past(addr_i)) // RULE15
    else $error("loaded address not latched");
  a_advance_step: assert property (adv && act_r |=> cnt_r == $past(cnt_r) + 2'h1
    && st1_addr_r[ADDR_W-1:BURST_W] == $past(base_r[ADDR_W-1:BURST_W])) // RULE2
    else $error("burst did not advance within group");
  a_deselect: assert property (load && !sel_ok ##1 qual |-> !st1_vld_r ##1 !drive_r) // RULE7
    else $error("deselect pattern selected device");
  a_read_pipe: assert property (load && sel_ok && write_strobe_n_i ##1 qual |=> drive_r) // RULE10
    else $error("read data not driven after two edges");
  a_write_timing: assert property (load && sel_ok && !write_strobe_n_i ##1 qual ##1 qual
    |-> push && !data_oe_o) // RULE17
    else $error("write data not taken two edges later");
  a_strap_hold: assert property (strap_done_r |=> $stable(order_r)) // RULE14
    else $error("burst order changed in operation");
  a_strobe_write: assert property (load && sel_ok && !write_strobe_n_i |=> st1_wr_r) // RULE1
    else $error("write strobe did not start write");

  c_read_burst: cover property (load && sel_ok && write_strobe_n_i ##1 adv [*3]);
  c_write_then_read: cover property (push ##1 drive_r);
  c_suspend_read: cover property (drive_r && clock_qualifier_n_i ##1 clock_qualifier_n_i);
  c_buffer_full: cover property (!wq_in_ready);
endmodule // burst_sram_device

`default_nettype wire

/* hdl/burst_sram_pkg.sv */
// Shared constants for the pipelined burst SRAM device logic.
// Assumes one rising-edge clock and an active-low asynchronous reset.
package burst_sram_pkg;
  // Array geometry: 256K words of four 9-bit lanes
  localparam int ADDR_W = 18;
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int DATA_W = 32;
  localparam int WORDS = 262144;
  // Burst counter covers the two low address bits
  localparam int BURST_W = 2;
  // Write buffer entry: address, lane mask, lane data
  localparam int WBUF_W = ADDR_W + LANES + LANES * LANE_W;
  localparam int WBUF_DEPTH = 4;
  // Values after reset
  localparam logic [BURST_W-1:0] CNT_RST = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
  localparam logic [LANES-1:0] LANE_N_RST = 4'hf;
  localparam logic ORDER_RST = 1'b1;
  // Burst order codes as seen on the strap
  localparam logic ORDER_LINEAR = 1'b0;
endpackage : burst_sram_pkg

/* tb/sram_master_model.sv */
// Bus master model that drives the burst SRAM pins from bench commands.
// Assumes the bench changes commands and the qualifier at rising edges.
`timescale 1ns/100ps
`default_nettype none
module sram_master_model (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic qual_n_i,
  input wire logic [1:0] cmd_i,
  input wire logic [2:0] sel_i,
  input wire logic [17:0] addr_i,
  input wire logic [35:0] wd_i,
  input wire logic [3:0] lanes_n_i,
  output logic [17:0] addr_o,
  output logic write_strobe_n_o,
  output logic advance_or_load_o,
  output logic select_low_a_n_o,
  output logic select_high_o,
  output logic select_low_b_n_o,
  output logic [3:0] byte_lane_write_n_o,
  output logic [31:0] data_o,
  output logic [3:0] parity_lines_o
);
  logic desel_r; // Last load left the part deselected
  logic wr_r; // Current burst writes
  logic wv_r; // Write data owed at the next qualified edge
  logic [35:0] wd_r; // Data of that write
  logic [35:0] bus_r; // Level on the data and parity lines
  logic wr_now; // Command on the pins is a write word
  // Never advance out of deselect: a fresh load is sent instead
  assign advance_or_load_o = (cmd_i == 2'h2) && !desel_r;
  assign write_strobe_n_o = (cmd_i != 2'h1);
  assign {select_low_a_n_o, select_high_o, select_low_b_n_o} = sel_i;
  assign addr_o = addr_i;
  assign byte_lane_write_n_o = lanes_n_i;
  assign wr_now = advance_or_load_o ? wr_r : (!write_strobe_n_o && sel_i == 3'h2);
  assign {parity_lines_o, data_o} = bus_r;
  // Burst kind follows loads on qualified edges only
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      desel_r <= 1'h1;
      wr_r <= 1'h0;
    end else if (!qual_n_i && !advance_or_load_o) begin
      desel_r <= (sel_i != 3'h2);
      wr_r <= !write_strobe_n_o;
    end
  end
  // Data two qualified edges after its command; idle lines toggle so stale data never matches
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wv_r <= 1'h0;
      wd_r <= 36'h0;
      bus_r <= 36'h0;
    end else if (!qual_n_i) begin
      wv_r <= wr_now;
      wd_r <= wd_i;
      bus_r <= wv_r ? wd_r : ~bus_r;
    end
  end
endmodule // sram_master_model
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the burst SRAM device core.
// Assumes sram_master_model turns bench commands into pin activity.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin err_total++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module tb;
  import burst_sram_pkg::*;
  // Row: command and inputs, then outputs seen just after it is applied
  typedef struct packed {
    logic [1:0] c; logic [2:0] s; logic [17:0] a; logic [35:0] w; logic [3:0] l;
    logic q; logic o; logic e; logic [35:0] d;
  } row_t;
  localparam logic [1:0] RD = 2'h0;
  localparam logic [1:0] WR = 2'h1;
  localparam logic [1:0] AD = 2'h2;
  localparam logic [2:0] S = 3'h2; // Selected
  localparam logic [2:0] X = 3'h7; // Deselected
  localparam logic [35:0] D0 = 36'h312345678, D1 = 36'hc9abcdef0, D2 = 36'h50f0f0f0f, D3 = 36'ha13572468;
  localparam logic [35:0] E = 36'hff0f0f0f0, P = 36'h0aabbccdd, Q = 36'haf0bbf0dd, Z = 36'h0;
  // Interleaved bursts, byte-lane merge, suspension inside a burst, read-write turnarounds
  localparam row_t TBL [25] = '{'{RD,X,0,Z,0,0,0,0,Z}, '{WR,S,18'h10,D0,0,0,0,0,Z},
    '{AD,S,0,D1,0,0,0,0,Z}, '{AD,S,0,D2,0,0,0,0,Z}, '{AD,S,0,D3,0,0,0,0,Z},
    '{WR,S,18'h21,E,0,0,0,0,Z}, '{WR,S,18'h21,P,4'ha,0,0,0,Z}, '{RD,X,0,Z,0,0,0,0,Z},
    '{RD,X,0,Z,0,0,0,0,Z}, '{RD,X,0,Z,0,0,0,0,Z}, '{RD,X,0,Z,0,0,0,0,Z},
    '{RD,S,18'h11,Z,0,0,0,0,Z}, '{AD,S,0,Z,0,0,0,0,Z}, '{AD,S,0,Z,0,1,0,1,D1},
    '{AD,S,0,Z,0,0,0,1,D1}, '{AD,S,0,Z,0,0,0,1,D0}, '{WR,S,18'h30,D1,0,0,0,1,D3},
    '{RD,S,18'h21,Z,0,0,0,1,D2}, '{RD,X,0,Z,0,0,0,0,Z}, '{AD,X,0,Z,0,0,0,1,Q},
    '{RD,X,0,Z,0,0,0,0,Z}, '{RD,X,0,Z,0,0,0,0,Z}, '{RD,S,18'h30,Z,0,0,0,0,Z},
    '{RD,X,0,Z,0,0,0,0,Z}, '{RD,X,0,Z,0,0,0,1,D1}};
  logic clk_sys_i, rstn_i, q, o, order;
  logic [1:0] c;
  logic [2:0] s;
  logic [17:0] a, addr;
  logic [35:0] w;
  logic [3:0] l, ln, pin, pout;
  logic we_n, adv, sa_n, sh, sb_n, oe, wbr;
  logic [31:0] din, dout;
  int err_total, n_tests;
  sram_master_model mdl_u (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .qual_n_i(q), .cmd_i(c), .sel_i(s),
    .addr_i(a), .wd_i(w), .lanes_n_i(l), .addr_o(addr), .write_strobe_n_o(we_n), .advance_or_load_o(adv),
    .select_low_a_n_o(sa_n), .select_high_o(sh), .select_low_b_n_o(sb_n), .byte_lane_write_n_o(ln),
    .data_o(din), .parity_lines_o(pin));
  burst_sram_device dut_u (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .addr_i(addr), .write_strobe_n_i(we_n),
    .advance_or_load_i(adv), .clock_qualifier_n_i(q), .select_low_a_n_i(sa_n), .select_high_i(sh),
    .select_low_b_n_i(sb_n), .byte_lane_write_n_i(ln), .output_drive_n_i(o), .burst_order_i(order),
    .data_i(din), .parity_lines_i(pin), .data_o(dout), .parity_lines_o(pout), .data_oe_o(oe),
    .write_buf_ready_o(wbr));
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  // Row without write data, for hand-written cases
  function automatic row_t R(logic [1:0] kc, logic [2:0] ks, logic [17:0] ka, logic kq, logic ko,
    logic ke, logic [35:0] kd);
    return '{kc, ks, ka, Z, 4'h0, kq, ko, ke, kd};
  endfunction
  // Apply one row at an edge, then look once that edge's updates have landed
  task automatic step(input row_t r);
    @(posedge clk_sys_i);
    {c, s, a, w, l, q, o} <= r[$bits(row_t)-1:37];
    #1;
    `CHK("drive enable", r.e, oe)
    if (r.e) `CHK("read word", r.d, {pout, dout})
  endtask
  task automatic do_reset(input logic ord);
    @(posedge clk_sys_i);
    rstn_i <= 1'b0;
    order <= ord;
    repeat (12) @(posedge clk_sys_i);
    `CHK("reset enable", 1'b0, oe)
    `CHK("reset word", 36'h0, {pout, dout})
    `CHK("reset room", 1'b1, wbr)
    rstn_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    #20000;
    err_total++;
    $display("[FAIL] watchdog expected finish seen hang");
    wrap_up();
  end
  initial begin
    {rstn_i, q, o, order, c, s, a, w, l} = {1'b0, 1'b0, 1'b0, 1'b1, RD, X, 18'h0, Z, 4'h0};
    err_total = 0;
    n_tests = 0;
    do_reset(1'b1);
    foreach (TBL[i]) step(TBL[i]);
    `CHK("write room", 1'b1, wbr)
    $display("test table done");
    do_reset(1'b0);
    step(R(RD, S, 18'h11, 0, 0, 0, Z));
    step(R(AD, S, 0, 0, 0, 0, Z));
    step(R(AD, S, 0, 0, 0, 1, D1));
    step(R(RD, X, 0, 0, 0, 1, D2));
    step(R(RD, X, 0, 0, 0, 1, D3));
    $display("test linear done");
    step(R(RD, S, 18'h10, 0, 0, 0, Z));
    step(R(RD, X, 0, 0, 0, 0, Z));
    step(R(RD, X, 0, 1, 0, 1, D0));
    step(R(RD, X, 0, 1, 1, 0, Z));
    step(R(RD, X, 0, 1, 0, 1, D0));
    step(R(RD, X, 0, 0, 0, 1, D0));
    step(R(RD, X, 0, 0, 0, 0, Z));
    $display("test suspend done");
    for (int k = 0; k < 8; k++) begin
      step(R(RD, k[2:0], 18'h10, 0, 0, 0, Z));
      step(R(RD, X, 0, 0, 0, 0, Z));
      step(R(RD, X, 0, 0, 0, (k == 2), D0));
    end
    $display("test selects done");
    wrap_up();
  end
endmodule // tb
`default_nettype wire
